// >>> bipm_pkg.sv
// Package for the bus idle and power mode controller.
// Assumes a single 250 MHz reference clock; all timing counts derive from it.
package bipm_pkg;
    // Clock rate
    localparam longint CLK_HZ = 64'd250000000;
    // Bus low period before the bus is declared off, in seconds
    localparam longint BUS_OFF_S = 64'd2;
    localparam longint BUS_OFF_CYC = BUS_OFF_S * CLK_HZ;
    // Longest time from bus release to ready, in microseconds (rounded down)
    localparam longint RESUME_US = 64'd1000;
    localparam longint RESUME_CYC = RESUME_US * CLK_HZ / 64'd1000000;
    // Normal mode cycle period, in milliseconds
    localparam longint NORMAL_MS = 64'd250;
    localparam longint NORMAL_CYC = NORMAL_MS * CLK_HZ / 64'd1000;
    // Default sleep interval, in milliseconds
    localparam longint SLEEP_MS = 64'd1000;
    localparam longint SLEEP_CYC = SLEEP_MS * CLK_HZ / 64'd1000;
    // Width of the interval counters
    localparam int CNT_W = 32;
    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;

    // Power modes as driven on the mode output
    typedef enum logic [1:0] {
        BIPM_NORMAL = 2'h0,
        BIPM_SLEEP = 2'h1,
        BIPM_SHUTDOWN = 2'h2
    } bipm_mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        BIPM_S_NORMAL,
        BIPM_S_CAL,
        BIPM_S_SLEEP,
        BIPM_S_SHUTDOWN
    } bipm_state_t;
endpackage : bipm_pkg

// >>> bipm_ctrl.sv
// Bus idle detection and power mode sequencing for a battery pack manager.
// Assumes bus pins arrive asynchronously; the other inputs come from logic on REF_CLK.
// Operation
// - The device talks over the two-wire management bus, with optional bus master and error check modes.
// - Both bus lines low for two seconds or more declares the bus off.
// - Bus off ends only when either line goes high, which the other party must cause.
// - Once bus off clears, the device is ready for bus traffic within one millisecond.
// - Normal mode runs one measurement and update cycle every 250 ms and idles between.
// - Sleep mode runs the same cycle at a configurable interval and idles between.
// - Sleep is left when pack current or a fault is detected.
// - Shutdown disables measurement, protection and communication entirely.
// - Both bus lines low sends the device through offset calibration into sleep.
`timescale 1ns/1ns
module bipm_ctrl
    import bipm_pkg::*;
#(
    parameter longint BUS_OFF_CYCLES = BUS_OFF_CYC,
    parameter longint RESUME_CYCLES = RESUME_CYC,
    parameter longint NORMAL_CYCLES = NORMAL_CYC,
    parameter longint SLEEP_DEFAULT_CYCLES = SLEEP_CYC
) (
    // Reference clock; every timer below counts its rising edges
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic BUS_CLOCK_PIN,
    input wire logic BUS_DATA_PIN,
    input wire logic MASTER_MODE_EN,
    input wire logic PEC_EN,
    input wire logic [CNT_W-1:0] SLEEP_INTERVAL,
    input wire logic SLEEP_REQ,
    input wire logic SHUTDOWN_REQ,
    input wire logic CURRENT_DETECT,
    input wire logic FAULT_DETECT,
    input wire logic CAL_DONE,
    output logic BUS_OFF,
    output logic BUS_READY,
    output logic MASTER_MODE,
    output logic PEC_MODE,
    output logic CAL_START,
    output logic MEAS_TICK,
    output logic LOW_POWER,
    output logic [1:0] POWER_MODE
);
    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] dat_sync;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] resume_cnt;
        logic [CNT_W-1:0] tick_cnt;
        logic bus_off;
        logic bus_ready;
        logic master_mode;
        logic pec_mode;
        logic cal_start;
        logic meas_tick;
        logic low_power;
        logic [1:0] power_mode;
        bipm_state_t state;
    } bipm_regs_t;

    // Registered copy of every piece of state, and its next value
    bipm_regs_t r_reg;
    bipm_regs_t r_next;
    // Both synchronised bus lines seen low in the same cycle
    logic both_low;
    // Measurement interval of the present mode, in clock cycles
    logic [CNT_W-1:0] period;

    // Timing notes for integrators:
    // Bus pins see two flip-flops first, so every bus decision lags the pins by two cycles.
    // The bus off flag itself adds one more register stage on top of that lag.
    // A single high cycle on either line is enough to restart the low timer.
    // Bus ready waits out the resume count after bus off clears, and after reset.
    // The resume count is one short of its limit, so ready lands inside the budget.
    // Sleep interval zero would stall the tick counter, so it selects the default.
    // Sleep interval changes take effect on the running count, not on the next tick.
    // Shutdown is sticky; only the reset pin brings the controller back.
    // Calibration entry does not wait for bus off; both lines low is enough.
    // Wake requests are only honoured while the sequencer sits in sleep.
    // Calibration ends only when the calibration engine reports done or shutdown is requested.

    // Synchronised line levels only; first stages feed nothing else
    assign both_low = ~r_reg.clk_sync[1] & ~r_reg.dat_sync[1];

    // Interval chosen by the current mode; zero interval selects the sleep default
    always_comb begin
        if (r_reg.state == BIPM_S_SLEEP) begin
            period = (SLEEP_INTERVAL == '0) ? CNT_W'(SLEEP_DEFAULT_CYCLES) : SLEEP_INTERVAL;
        end else begin
            period = CNT_W'(NORMAL_CYCLES);
        end
    end

    // Next-state logic for the whole controller
    // Later blocks override earlier ones, so shutdown sits last on purpose
    always_comb begin
        r_next = r_reg;
        r_next.clk_sync = {r_reg.clk_sync[0], BUS_CLOCK_PIN};
        r_next.dat_sync = {r_reg.dat_sync[0], BUS_DATA_PIN};
        r_next.cal_start = 1'b0;
        r_next.meas_tick = 1'b0;

        // Bus off detection; restart on any high line
        // Set and clear cannot meet: one needs both lines low, the other a high line
        if (!both_low) begin
            r_next.low_cnt = '0;
            if (r_reg.bus_off) begin
                r_next.bus_off = 1'b0;
                r_next.resume_cnt = '0;
            end
        end else if (!r_reg.bus_off) begin
            if (r_reg.low_cnt >= CNT_W'(BUS_OFF_CYCLES - 1)) begin
                r_next.bus_off = 1'b1;
                r_next.bus_ready = 1'b0;
            end else begin
                r_next.low_cnt = r_reg.low_cnt + 1'b1;
            end
        end

        // Resume timer: ready right at the limit, with the compare one count short of it
        // Also runs out of reset, so the bus is not answered straight away
        if (!r_reg.bus_off && !r_reg.bus_ready && r_reg.state != BIPM_S_SHUTDOWN) begin
            if (r_reg.resume_cnt >= CNT_W'(RESUME_CYCLES - 1)) begin
                r_next.bus_ready = 1'b1;
            end else begin
                r_next.resume_cnt = r_reg.resume_cnt + 1'b1;
            end
        end

        // Bus options are live only while communicating
        r_next.master_mode = MASTER_MODE_EN & r_next.bus_ready;
        r_next.pec_mode = PEC_EN & r_next.bus_ready;

        // Periodic measurement cycle in normal and sleep
        // Low power drops only for the tick cycle itself
        if (r_reg.state == BIPM_S_NORMAL || r_reg.state == BIPM_S_SLEEP) begin
            if (r_reg.tick_cnt >= period - 1'b1) begin
                r_next.tick_cnt = '0;
                r_next.meas_tick = 1'b1;
            end else begin
                r_next.tick_cnt = r_reg.tick_cnt + 1'b1;
            end
            r_next.low_power = r_next.meas_tick ? 1'b0 : 1'b1;
        end

        // Mode sequencer; shutdown wins over everything
        case (r_reg.state)
            // Pack removal or a sleep request both go through calibration
            BIPM_S_NORMAL: begin
                if (both_low || SLEEP_REQ) begin
                    r_next.state = BIPM_S_CAL;
                    r_next.cal_start = 1'b1;
                end
            end
            // Measurement paused; power stays up while calibrating
            BIPM_S_CAL: begin
                r_next.low_power = 1'b0;
                if (CAL_DONE) begin
                    r_next.state = BIPM_S_SLEEP;
                    r_next.power_mode = BIPM_SLEEP;
                    r_next.tick_cnt = '0;
                end
            end
            // Either wake source returns to normal with a fresh interval
            BIPM_S_SLEEP: begin
                if (CURRENT_DETECT || FAULT_DETECT) begin
                    r_next.state = BIPM_S_NORMAL;
                    r_next.power_mode = BIPM_NORMAL;
                    r_next.tick_cnt = '0;
                end
            end
            // Only bus off detection runs here; the override below stops the rest
            BIPM_S_SHUTDOWN: begin
                r_next.low_power = 1'b1;
            end
            // Unused encodings fall back to normal
            default: begin
                r_next.state = BIPM_S_NORMAL;
            end
        endcase

        // Shutdown stops every activity except bus off detection and holds until reset
        if (SHUTDOWN_REQ || r_reg.state == BIPM_S_SHUTDOWN) begin
            r_next.state = BIPM_S_SHUTDOWN;
            r_next.power_mode = BIPM_SHUTDOWN;
            r_next.meas_tick = 1'b0;
            r_next.cal_start = 1'b0;
            r_next.bus_ready = 1'b0;
            r_next.master_mode = 1'b0;
            r_next.pec_mode = 1'b0;
            r_next.low_power = 1'b1;
            r_next.tick_cnt = '0;
        end
    end

    // State register; constants only under reset
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_reg <= '0;
            r_reg.clk_sync <= 2'h3;
            r_reg.dat_sync <= 2'h3;
            r_reg.power_mode <= MODE_RST;
            r_reg.state <= BIPM_S_NORMAL;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register, no logic after the flops
    assign BUS_OFF = r_reg.bus_off;
    assign BUS_READY = r_reg.bus_ready;
    assign MASTER_MODE = r_reg.master_mode;
    assign PEC_MODE = r_reg.pec_mode;
    assign CAL_START = r_reg.cal_start;
    assign MEAS_TICK = r_reg.meas_tick;
    assign LOW_POWER = r_reg.low_power;
    assign POWER_MODE = r_reg.power_mode;
endmodule : bipm_ctrl

// >>> bipm_host.sv
// Host side of the two-wire bus.
// Released lines fall low through the device pull-downs.
`timescale 1ns/1ns
module bipm_host (input wire logic rel, input wire logic kick, output logic scl, output logic sda);
    // Only a high drive from this side ends bus off
    assign scl = !rel;
    assign sda = !rel || kick;
endmodule : bipm_host

// >>> bipm_ctrl_assertions.sv
// Checker for the bus idle and power mode controller.
// Bound to bipm_ctrl; sees its ports only.
`timescale 1ns/1ns
module bipm_ctrl_assertions
    import bipm_pkg::*;
#(parameter longint BUS_OFF_CYCLES = BUS_OFF_CYC, parameter longint RESUME_CYCLES = RESUME_CYC,
    parameter longint NORMAL_CYCLES = NORMAL_CYC) (
    input wire logic REF_CLK, RESET_N, BUS_CLOCK_PIN, BUS_DATA_PIN, MASTER_MODE_EN, PEC_EN,
    input wire logic CURRENT_DETECT, FAULT_DETECT, SHUTDOWN_REQ, BUS_OFF, BUS_READY,
    input wire logic MASTER_MODE, PEC_MODE, MEAS_TICK, LOW_POWER,
    input wire logic [1:0] POWER_MODE
);
    localparam int BOC = int'(BUS_OFF_CYCLES);
    localparam int RC = int'(RESUME_CYCLES) + 3;
    localparam int NC = int'(NORMAL_CYCLES);
    int lc;
    int rc;
    int tc;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // Run of both lines low, saturating so it cannot wrap
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) lc <= 0;
        else lc <= (BUS_CLOCK_PIN || BUS_DATA_PIN) ? 0 : (lc > BOC + 8 ? lc : lc + 1);
    end
    // Cycles waiting for ready; a counter, since the real wait is too long for a range
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) rc <= 0;
        else rc <= (BUS_OFF || BUS_READY) ? 0 : (rc > RC ? rc : rc + 1);
    end
    // Cycles since the last measurement pulse, saturating
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) tc <= 0;
        else tc <= MEAS_TICK ? 0 : (tc > NC ? tc : tc + 1);
    end
    property p_early; $rose(BUS_OFF) |-> lc >= BOC; endproperty
    a_early: assert property (p_early) else $error("bus off early");
    property p_off; lc > BOC + 4 && POWER_MODE != BIPM_SHUTDOWN |-> BUS_OFF && !BUS_READY; endproperty
    a_off: assert property (p_off) else $error("bus off missing");
    property p_hold; BUS_OFF && lc > 3 |=> BUS_OFF; endproperty
    a_hold: assert property (p_hold) else $error("bus off left low");
    property p_res; !BUS_OFF && !BUS_READY && POWER_MODE != BIPM_SHUTDOWN |-> rc <= RC;
    endproperty
    a_res: assert property (p_res) else $error("resume late");
    property p_opt; BUS_READY && $past(BUS_READY) |->
        MASTER_MODE == $past(MASTER_MODE_EN) && PEC_MODE == $past(PEC_EN); endproperty
    a_opt: assert property (p_opt) else $error("option wrong");
    property p_tick; MEAS_TICK && POWER_MODE == BIPM_NORMAL |-> tc >= NC - 1; endproperty
    a_tick: assert property (p_tick) else $error("tick period");
    property p_wake; POWER_MODE == BIPM_SLEEP && (CURRENT_DETECT || FAULT_DETECT) &&
        !SHUTDOWN_REQ |=> POWER_MODE == BIPM_NORMAL; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_shut; POWER_MODE == BIPM_SHUTDOWN |=>
        POWER_MODE == BIPM_SHUTDOWN && !MEAS_TICK && !BUS_READY && LOW_POWER; endproperty
    a_shut: assert property (p_shut) else $error("shutdown active");
endmodule : bipm_ctrl_assertions
bind bipm_ctrl bipm_ctrl_assertions #(.BUS_OFF_CYCLES(BUS_OFF_CYCLES),
    .RESUME_CYCLES(RESUME_CYCLES), .NORMAL_CYCLES(NORMAL_CYCLES)) u_chk (.REF_CLK, .RESET_N,
    .BUS_CLOCK_PIN, .BUS_DATA_PIN, .MASTER_MODE_EN, .PEC_EN, .CURRENT_DETECT, .FAULT_DETECT,
    .SHUTDOWN_REQ, .BUS_OFF, .BUS_READY, .MASTER_MODE, .PEC_MODE, .MEAS_TICK, .LOW_POWER,
    .POWER_MODE);

// >>> tb_bipm_ctrl.sv
// Bench for the bus idle and power mode controller.
// Assumes bipm_host on the bus pins and the bound checker.
`timescale 1ns/1ns
module tb_bipm_ctrl;
    import bipm_pkg::*;
    logic clk = 0, rst_n = 0, rel = 0, kick = 0, men = 0, pen = 0, slp = 0, shd = 0;
    logic cur = 0, flt = 0, cdn = 0, scl, sda, boff, rdy, mm, pm, cst, tick, lp;
    logic [1:0] mode;
    logic [31:0] siv = 32'h0000000c;
    int n_errors = 0, n_checks = 0, g;
    always #2 clk = ~clk;
    bipm_host host (.rel(rel), .kick(kick), .scl(scl), .sda(sda));
    // Short counts keep the run brief
    bipm_ctrl #(.BUS_OFF_CYCLES(40), .RESUME_CYCLES(10), .NORMAL_CYCLES(20),
        .SLEEP_DEFAULT_CYCLES(30)) dut (.REF_CLK(clk), .RESET_N(rst_n), .BUS_CLOCK_PIN(scl),
        .BUS_DATA_PIN(sda), .MASTER_MODE_EN(men), .PEC_EN(pen), .SLEEP_INTERVAL(siv),
        .SLEEP_REQ(slp), .SHUTDOWN_REQ(shd), .CURRENT_DETECT(cur), .FAULT_DETECT(flt),
        .CAL_DONE(cdn), .BUS_OFF(boff), .BUS_READY(rdy), .MASTER_MODE(mm), .PEC_MODE(pm),
        .CAL_START(cst), .MEAS_TICK(tick), .LOW_POWER(lp), .POWER_MODE(mode));
    task automatic cyc(input int n); repeat (n) @(negedge clk); endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, e, s); end
    endtask : chk
    // Cycles between two measurement pulses, bounded
    task automatic gap();
        for (g = 0; g < 200 && tick !== 1'b1; g++) cyc(1);
        g = 0;
        do begin cyc(1); g++; end while (tick !== 1'b1 && g < 200);
    endtask : gap
    task automatic t_ready();
        cyc(16); chk("ready", 1, rdy);
        men = 1; cyc(3); chk("mst", 1, mm);
        men = 0; pen = 1; cyc(3); chk("mst", 0, mm);
        chk("pec", 1, pm);
        gap(); chk("ngap", 20, g);
        cyc(2); chk("idle", 1, lp);
    endtask : t_ready
    // Lines dropped: calibrate, sleep, glitch restarts the timer, then bus off
    task automatic t_bus_off();
        rel = 1;
        for (g = 0; g < 8 && cst !== 1'b1; g++) cyc(1);
        chk("cal", 1, cst);
        cdn = 1; cyc(1); cdn = 0; cyc(1); chk("slp", 1, mode);
        cyc(20); kick = 1; cyc(1); kick = 0; cyc(35); chk("off0", 0, boff);
        cyc(10); chk("off1", 1, boff);
        chk("rdy0", 0, rdy);
        rel = 0; cyc(4); chk("on", 0, boff);
        cyc(12); chk("rdy1", 1, rdy);
    endtask : t_bus_off
    task automatic t_sleep();
        gap(); chk("sgap", 12, g);
        cur = 1; cyc(1); cur = 0; chk("wcur", 0, mode);
        slp = 1; cyc(4); cdn = 1; cyc(1); cdn = 0; slp = 0; cyc(1); chk("s2", 1, mode);
        siv = 32'h00000000; gap(); chk("sdef", 30, g);
        flt = 1; cyc(1); flt = 0; chk("wflt", 0, mode);
    endtask : t_sleep
    task automatic t_shut();
        shd = 1; cyc(2); shd = 0; chk("shut", 2, mode);
        for (g = 0; g < 60 && tick !== 1'b1; g++) cyc(1);
        chk("noticks", 60, g);
        chk("nordy", 0, rdy);
    endtask : t_shut
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    initial begin
        cyc(4); rst_n = 1;
        t_ready(); t_bus_off(); t_sleep(); t_shut(); close_out();
    end
    // Watchdog well past the expected run
    initial begin #20000; n_errors++; close_out(); end
endmodule : tb_bipm_ctrl
